// file: pkg/irct_pkg.sv
// What this block does
// R1: match of counter and modulo sets flag
// R2: count read only, modulo write only
// R3: select fx/32, fx/64, fx/256 or carrier
// R4: clear bit zeroes counter and flag
// R5: enable bit gates counting on falling edge
// R6: control word resets to 8H, counting enabled
// R7: software must never load modulo zero
// R8: carrier counter is 7 bits at fx/2
// R9: each phase lasts period plus one ticks
// R10: period registers read and write, low at 03H
// R11: low period bit 7 picks steady high
// R12: live enable zero drives pin low
// R13: timer match copies staged into live enable
// R14: pin update waits for carrier clock low
// R15: carrier stops unless live or pin enable is set or timer uses it
// R16: carrier-clocked timer delays first high pulse
// R17: counter restarts at zero after match
// R18: phases alternate, reload, start with high
package irct_pkg;

  // ---------------------------------------------
  // peripheral register addresses
  // ---------------------------------------------
  localparam logic [7:0] PER_LOW_PERIOD = 8'h03;
  localparam logic [7:0] PER_HIGH_PERIOD = 8'h04;
  localparam logic [7:0] PER_COUNT = 8'h05;
  localparam logic [7:0] PER_MATCH = 8'h06;

  // ---------------------------------------------
  // register file addresses and fields
  // ---------------------------------------------
  localparam logic [6:0] RF_TIMER_CONTROL = 7'h33;
  localparam logic [6:0] RF_MATCH_FLAG = 7'h3f;
  localparam logic [6:0] RF_CARRIER_ENABLE = 7'h31;
  localparam int CTL_SEL_LSB = 0;
  localparam int CTL_CLEAR_BIT = 2;
  localparam int CTL_ENABLE_BIT = 3;
  localparam int FLAG_BIT = 0;
  localparam int LIVE_BIT = 0;
  localparam int STAGED_BIT = 1;
  localparam int STEADY_BIT = 7;

  // ---------------------------------------------
  // reset values
  // ---------------------------------------------
  localparam logic [3:0] CTL_RESET = 4'h8;
  localparam logic [7:0] MATCH_RESET = 8'hff;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] LOW_PERIOD_RESET = 8'h00;
  localparam logic [6:0] HIGH_PERIOD_RESET = 7'h00;

  // ---------------------------------------------
  // clock select codes and divider taps
  // ---------------------------------------------
  localparam logic [1:0] SEL_DIV32 = 2'b00;
  localparam logic [1:0] SEL_DIV64 = 2'b01;
  localparam logic [1:0] SEL_DIV256 = 2'b10;
  localparam logic [1:0] SEL_CARRIER = 2'b11;
  localparam logic [7:0] DIV32_MASK = 8'h1f;
  localparam logic [7:0] DIV64_MASK = 8'h3f;
  localparam logic [7:0] DIV256_MASK = 8'hff;

  // ---------------------------------------------
  // carrier phase states
  // ---------------------------------------------
  typedef enum logic [1:0] {
    IRCT_IDLE,
    IRCT_HIGH,
    IRCT_LOW
  } irct_phase_t;

endpackage

// file: logic/irct_top.sv
module irct_top #(
  parameter int CARRIER_BITS = 7
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [6:0] rf_addr,
  input wire logic rf_wr,
  input wire logic rf_rd,
  input wire logic [3:0] rf_wdata,
  output logic [3:0] rf_rdata,
  input wire logic [7:0] per_addr,
  input wire logic per_put,
  input wire logic per_get,
  input wire logic [7:0] data_buffer_word,
  output logic [7:0] per_rdata,
  output logic timer_match_flag,
  output logic ir_drive_pin
);

  // ---------------------------------------------
  // state
  // ---------------------------------------------
  logic [3:0] ctl_r;
  logic [7:0] timer_count_value_r;
  logic [7:0] timer_match_value_r;
  logic [7:0] carrier_low_period_r;
  logic [CARRIER_BITS-1:0] carrier_high_period_r;
  logic match_flag_r;
  logic live_en_r;
  logic staged_carrier_enable_r;
  logic pin_en_r;
  logic pin_r;
  logic half_r;
  logic [7:0] presc_r;
  logic [CARRIER_BITS-1:0] phase_cnt_r;
  logic [CARRIER_BITS-1:0] phase_lim_r;
  irct_pkg::irct_phase_t phase_r;
  logic [3:0] rf_rdata_r;
  logic [7:0] per_rdata_r;

  logic ctl_wr;
  logic clear_req;
  logic count_en;
  logic [1:0] clk_sel;
  logic half_tick;
  logic carr_hi;
  logic carr_fall;
  logic count_tick;
  logic match_pulse;
  logic carr_run;
  logic pin_en_nxt;
  logic carr_hi_nxt;
  logic steady;

  function automatic logic presc_tap(input logic [7:0] cnt, input logic [7:0] mask);
    presc_tap = (cnt & mask) == mask;
  endfunction

  assign ctl_wr = rf_wr && rf_addr == irct_pkg::RF_TIMER_CONTROL;
  assign clear_req = ctl_wr && rf_wdata[irct_pkg::CTL_CLEAR_BIT];
  assign count_en = ctl_r[irct_pkg::CTL_ENABLE_BIT];
  assign clk_sel = ctl_r[irct_pkg::CTL_SEL_LSB +: 2];
  assign carr_hi = phase_r == irct_pkg::IRCT_HIGH;
  assign steady = carrier_low_period_r[irct_pkg::STEADY_BIT];

  // ---------------------------------------------
  // dividers
  // ---------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      half_r <= 1'b0;
      presc_r <= 8'h00;
    end else begin
      half_r <= ~half_r;
      presc_r <= presc_r + 8'h01;
    end
  end

  assign half_tick = half_r; // R8

  // ---------------------------------------------
  // count clock selection
  // ---------------------------------------------
  always_comb begin
    case (clk_sel) // R3
      irct_pkg::SEL_DIV32: count_tick = presc_tap(presc_r, irct_pkg::DIV32_MASK);
      irct_pkg::SEL_DIV64: count_tick = presc_tap(presc_r, irct_pkg::DIV64_MASK);
      irct_pkg::SEL_DIV256: count_tick = presc_tap(presc_r, irct_pkg::DIV256_MASK);
      default: count_tick = carr_fall;
    endcase
  end

  // ---------------------------------------------
  // control word and timer counter
  // ---------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ctl_r <= irct_pkg::CTL_RESET; // R6
    end else if (ctl_wr) begin
      ctl_r <= {rf_wdata[irct_pkg::CTL_ENABLE_BIT], 1'b0, rf_wdata[1:0]}; // R4
    end
  end

  // match 0 is reached by increment only from FFH, so flag sets at most once
  assign match_pulse = !clear_req && count_en && count_tick && timer_count_value_r != timer_match_value_r
    && timer_count_value_r + 8'h01 == timer_match_value_r; // R1 R7

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      timer_count_value_r <= irct_pkg::COUNT_RESET;
    end else if (clear_req) begin
      timer_count_value_r <= 8'h00; // R4
    end else if (count_en && count_tick) begin // R5
      if (timer_count_value_r == timer_match_value_r) begin
        timer_count_value_r <= 8'h00; // R17
      end else begin
        timer_count_value_r <= timer_count_value_r + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      timer_match_value_r <= irct_pkg::MATCH_RESET;
    end else if (per_put && per_addr == irct_pkg::PER_MATCH) begin
      timer_match_value_r <= data_buffer_word; // R2
    end
  end

  // ---------------------------------------------
  // match flag, set wins over flag write, clear bit wins over set
  // ---------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      match_flag_r <= 1'b0;
    end else if (match_pulse) begin
      match_flag_r <= 1'b1; // R1
    end else if (clear_req) begin
      match_flag_r <= 1'b0; // R4
    end else if (rf_wr && rf_addr == irct_pkg::RF_MATCH_FLAG) begin
      match_flag_r <= rf_wdata[irct_pkg::FLAG_BIT];
    end
  end

  assign timer_match_flag = match_flag_r;

  // ---------------------------------------------
  // carrier enables
  // ---------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      staged_carrier_enable_r <= 1'b0;
    end else if (rf_wr && rf_addr == irct_pkg::RF_CARRIER_ENABLE) begin
      staged_carrier_enable_r <= rf_wdata[irct_pkg::STAGED_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      live_en_r <= 1'b0;
    end else if (match_pulse) begin
      live_en_r <= staged_carrier_enable_r; // R13
    end else if (rf_wr && rf_addr == irct_pkg::RF_CARRIER_ENABLE) begin
      live_en_r <= rf_wdata[irct_pkg::LIVE_BIT];
    end
  end

  // ---------------------------------------------
  // period registers
  // ---------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      carrier_low_period_r <= irct_pkg::LOW_PERIOD_RESET;
      carrier_high_period_r <= irct_pkg::HIGH_PERIOD_RESET;
    end else if (per_put) begin
      if (per_addr == irct_pkg::PER_LOW_PERIOD) begin
        carrier_low_period_r <= data_buffer_word; // R10
      end
      if (per_addr == irct_pkg::PER_HIGH_PERIOD) begin
        carrier_high_period_r <= data_buffer_word[CARRIER_BITS-1:0]; // R10
      end
    end
  end

  // ---------------------------------------------
  // carrier generator
  // ---------------------------------------------
  // run on while a held high pulse finishes
  assign carr_run = live_en_r || pin_en_r
    || clk_sel == irct_pkg::SEL_CARRIER; // R15 R14

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      phase_r <= irct_pkg::IRCT_IDLE;
      phase_cnt_r <= '0;
      phase_lim_r <= '0;
    end else if (!carr_run) begin
      phase_r <= irct_pkg::IRCT_IDLE; // R15
      phase_cnt_r <= '0;
    end else begin
      case (phase_r)
        irct_pkg::IRCT_IDLE: begin
          phase_r <= irct_pkg::IRCT_HIGH; // R18
          phase_cnt_r <= '0;
          phase_lim_r <= carrier_high_period_r;
        end
        irct_pkg::IRCT_HIGH: begin
          if (half_tick) begin
            if (phase_cnt_r == phase_lim_r) begin
              phase_r <= irct_pkg::IRCT_LOW; // R9
              phase_cnt_r <= '0;
              phase_lim_r <= carrier_low_period_r[CARRIER_BITS-1:0]; // R18
            end else begin
              phase_cnt_r <= phase_cnt_r + 1'b1; // R8
            end
          end
        end
        irct_pkg::IRCT_LOW: begin
          if (half_tick) begin
            if (phase_cnt_r == phase_lim_r) begin
              phase_r <= irct_pkg::IRCT_HIGH; // R9
              phase_cnt_r <= '0;
              phase_lim_r <= carrier_high_period_r; // R18
            end else begin
              phase_cnt_r <= phase_cnt_r + 1'b1;
            end
          end
        end
        default: begin
          phase_r <= irct_pkg::IRCT_IDLE;
        end
      endcase
    end
  end

  // count clock falls when the high phase ends
  assign carr_fall = carr_run && carr_hi && half_tick && phase_cnt_r == phase_lim_r; // R3 R16

  // ---------------------------------------------
  // pin drive
  // ---------------------------------------------
  assign carr_hi_nxt = carr_run && (phase_r == irct_pkg::IRCT_IDLE || (carr_hi != carr_fall)
    || (phase_r == irct_pkg::IRCT_LOW && half_tick && phase_cnt_r == phase_lim_r));

  // hold the old enable while pin and carrier are high
  assign pin_en_nxt = (pin_r && pin_en_r && carr_hi_nxt) ? pin_en_r : live_en_r; // R14

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pin_en_r <= 1'b0;
      pin_r <= 1'b0;
    end else begin
      pin_en_r <= pin_en_nxt;
      pin_r <= pin_en_nxt && (steady || carr_hi_nxt); // R11 R12
    end
  end

  assign ir_drive_pin = pin_r;

  // ---------------------------------------------
  // read paths
  // ---------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rf_rdata_r <= 4'h0;
    end else if (rf_rd) begin
      case (rf_addr)
        irct_pkg::RF_TIMER_CONTROL: rf_rdata_r <= {ctl_r[3], 1'b0, ctl_r[1:0]}; // R4
        irct_pkg::RF_MATCH_FLAG: rf_rdata_r <= {3'b000, match_flag_r};
        irct_pkg::RF_CARRIER_ENABLE: rf_rdata_r <= {2'b00, staged_carrier_enable_r, live_en_r};
        default: rf_rdata_r <= 4'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      per_rdata_r <= 8'h00;
    end else if (per_get) begin
      case (per_addr)
        irct_pkg::PER_LOW_PERIOD: per_rdata_r <= carrier_low_period_r; // R10
        irct_pkg::PER_HIGH_PERIOD: per_rdata_r <= {1'b0, carrier_high_period_r};
        irct_pkg::PER_COUNT: per_rdata_r <= timer_count_value_r; // R2
        default: per_rdata_r <= 8'h00;
      endcase
    end
  end

  assign rf_rdata = rf_rdata_r;
  assign per_rdata = per_rdata_r;

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  flag_set_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R1
    match_pulse |=> match_flag_r && timer_count_value_r == timer_match_value_r)
    else $error("match did not set flag");

  match_hidden_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R2
    per_get && per_addr == irct_pkg::PER_MATCH |=> per_rdata == 8'h00)
    else $error("modulo value visible on read");

  clear_both_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R4
    clear_req |=> timer_count_value_r == 8'h00 && !match_flag_r && !ctl_r[irct_pkg::CTL_CLEAR_BIT])
    else $error("clear bit failed");

  stop_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R5
    !count_en && !clear_req |=> $stable(timer_count_value_r))
    else $error("counter moved while stopped");

  wrap_zero_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R17
    count_en && count_tick && !clear_req && timer_count_value_r == timer_match_value_r
    |=> timer_count_value_r == 8'h00 && !$rose(match_flag_r))
    else $error("counter did not restart");

  enable_copy_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R13
    match_pulse |=> live_en_r == $past(staged_carrier_enable_r))
    else $error("staged enable not copied");

  phase_len_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R9
    carr_run && carr_hi && half_tick && phase_cnt_r == phase_lim_r ##1 carr_run
    |-> phase_r == irct_pkg::IRCT_LOW && phase_cnt_r == '0)
    else $error("phase did not end at period");

  carrier_stop_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R15
    !live_en_r && !pin_en_r && clk_sel != irct_pkg::SEL_CARRIER
    |=> phase_r == irct_pkg::IRCT_IDLE)
    else $error("carrier ran while disabled");

  pin_low_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R12
    !pin_en_r |-> !ir_drive_pin)
    else $error("pin high while disabled");

  steady_high_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R11
    pin_en_nxt && steady |=> ir_drive_pin)
    else $error("steady level missing");

  defer_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R14
    pin_r && pin_en_r && !live_en_r && carr_hi_nxt |=> pin_en_r)
    else $error("enable applied during high pulse");

endmodule

// file: verif/irct_cpu_model.sv
module irct_cpu_model (
  input wire logic core_clk,
  output logic [6:0] rf_addr,
  output logic rf_wr,
  output logic rf_rd,
  output logic [3:0] rf_wdata,
  input wire logic [3:0] rf_rdata,
  output logic [7:0] per_addr,
  output logic per_put,
  output logic per_get,
  output logic [7:0] data_buffer_word,
  input wire logic [7:0] per_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rf_addr = 7'h00;
    rf_wr = 1'b0;
    rf_rd = 1'b0;
    rf_wdata = 4'h0;
    per_addr = 8'h00;
    per_put = 1'b0;
    per_get = 1'b0;
    data_buffer_word = 8'h00;
  end
  // ---------------------------------------------
  // register file access, one word
  // ---------------------------------------------
  task automatic rf_acc(input logic wr, input logic [6:0] a, input logic [3:0] d, output logic [3:0] q);
    @(posedge core_clk);
    rf_addr <= a;
    rf_wdata <= d;
    rf_wr <= wr;
    rf_rd <= ~wr;
    @(posedge core_clk);
    rf_wr <= 1'b0;
    rf_rd <= 1'b0;
    rf_addr <= ~a;
    rf_wdata <= ~d;
    #1 q = rf_rdata;
  endtask
  // ---------------------------------------------
  // peripheral access through the data buffer
  // ---------------------------------------------
  task automatic per_acc(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    q = 8'h00;
    if (wr && a == 8'h06 && d == 8'h00) return;
    @(posedge core_clk);
    per_addr <= a;
    data_buffer_word <= d;
    per_put <= wr;
    per_get <= ~wr;
    @(posedge core_clk);
    per_put <= 1'b0;
    per_get <= 1'b0;
    per_addr <= ~a;
    data_buffer_word <= ~d;
    #1 q = per_rdata;
  endtask
endmodule

// file: verif/test_ir_carrier_modulo_timer.sv
module test_ir_carrier_modulo_timer;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [6:0] rf_addr;
  logic rf_wr;
  logic rf_rd;
  logic [3:0] rf_wdata;
  logic [3:0] rf_rdata;
  logic [7:0] per_addr;
  logic per_put;
  logic per_get;
  logic [7:0] data_buffer_word;
  logic [7:0] per_rdata;
  logic timer_match_flag;
  logic ir_drive_pin;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  logic [3:0] q4;
  logic [7:0] q8;

  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;

  irct_top #(.CARRIER_BITS(7)) dut_u (.core_clk(core_clk), .rst_b(rst_b), .rf_addr(rf_addr), .rf_wr(rf_wr),
    .rf_rd(rf_rd), .rf_wdata(rf_wdata), .rf_rdata(rf_rdata), .per_addr(per_addr), .per_put(per_put),
    .per_get(per_get), .data_buffer_word(data_buffer_word), .per_rdata(per_rdata),
    .timer_match_flag(timer_match_flag), .ir_drive_pin(ir_drive_pin));

  irct_cpu_model cpu_u (.core_clk(core_clk), .rf_addr(rf_addr), .rf_wr(rf_wr), .rf_rd(rf_rd), .rf_wdata(rf_wdata),
    .rf_rdata(rf_rdata), .per_addr(per_addr), .per_put(per_put), .per_get(per_get),
    .data_buffer_word(data_buffer_word), .per_rdata(per_rdata));

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      err_count++;
    end
  endtask

  task automatic wait_sig(input bit pin, input logic v);
    for (int i = 0; i < 3000; i++) begin
      @(posedge core_clk);
      #1;
      if ((pin ? ir_drive_pin : timer_match_flag) === v) return;
    end
    err_count++;
  endtask

  task automatic pin_len(input logic v, output int n);
    n = 0;
    while (ir_drive_pin === v && n < 500) begin
      @(posedge core_clk);
      #1 n++;
    end
  endtask

  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic reset_values();
    cpu_u.rf_acc(1'b0, 7'h33, 4'h0, q4);
    check(q4, 4'h8);
    cpu_u.rf_acc(1'b0, 7'h3f, 4'h0, q4);
    check(q4, 4'h0);
    cpu_u.per_acc(1'b0, 8'h06, 8'h00, q8);
    check(q8, 8'h00);
  endtask

  task automatic reg_access();
    cpu_u.rf_acc(1'b1, 7'h33, 4'h4, q4);
    cpu_u.rf_acc(1'b0, 7'h33, 4'h0, q4);
    check(q4, 4'h0);
    cpu_u.per_acc(1'b1, 8'h05, 8'h5a, q8);
    repeat (100) @(posedge core_clk);
    cpu_u.per_acc(1'b0, 8'h05, 8'h00, q8);
    check(q8, 8'h00);
    cpu_u.per_acc(1'b1, 8'h03, 8'h85, q8);
    cpu_u.per_acc(1'b0, 8'h03, 8'h00, q8);
    check(q8, 8'h85);
    cpu_u.per_acc(1'b1, 8'h04, 8'hff, q8);
    cpu_u.per_acc(1'b0, 8'h04, 8'h00, q8);
    check(q8, 8'h7f);
    cpu_u.per_acc(1'b0, 8'h80, 8'h00, q8);
    check(q8, 8'h00);
    cpu_u.rf_acc(1'b0, 7'h10, 4'h0, q4);
    check(q4, 4'h0);
  endtask

  task automatic timer_periods();
    int t1;
    int div [4] = '{32, 64, 256, 10};
    cpu_u.per_acc(1'b1, 8'h04, 8'h01, q8);
    cpu_u.per_acc(1'b1, 8'h03, 8'h02, q8);
    cpu_u.per_acc(1'b1, 8'h06, 8'h03, q8);
    for (int s = 0; s < 4; s++) begin
      cpu_u.rf_acc(1'b1, 7'h33, {2'b11, s[1:0]}, q4);
      wait_sig(1'b0, 1'b1);
      t1 = cyc;
      cpu_u.rf_acc(1'b1, 7'h3f, 4'h0, q4);
      wait_sig(1'b0, 1'b1);
      check(cyc - t1, 4 * div[s]);
    end
    cpu_u.per_acc(1'b0, 8'h06, 8'h00, q8);
    check(q8, 8'h00);
  endtask

  task automatic carrier_pin();
    int n;
    cpu_u.rf_acc(1'b1, 7'h33, 4'hc, q4);
    cpu_u.rf_acc(1'b1, 7'h31, 4'h2, q4);
    cpu_u.rf_acc(1'b0, 7'h31, 4'h0, q4);
    check(q4, 4'h2);
    repeat (20) @(posedge core_clk);
    #1 check(ir_drive_pin, 1'b0);
    wait_sig(1'b0, 1'b1);
    wait_sig(1'b1, 1'b1);
    wait_sig(1'b1, 1'b0);
    wait_sig(1'b1, 1'b1);
    pin_len(1'b1, n);
    check(n, 4);
    pin_len(1'b0, n);
    check(n, 6);
    cpu_u.per_acc(1'b1, 8'h03, 8'h82, q8);
    repeat (10) @(posedge core_clk);
    pin_len(1'b1, n);
    check(n, 500);
    cpu_u.rf_acc(1'b1, 7'h31, 4'h1, q4);
    cpu_u.rf_acc(1'b1, 7'h3f, 4'h0, q4);
    wait_sig(1'b0, 1'b1);
    repeat (8) @(posedge core_clk);
    #1 check(ir_drive_pin, 1'b0);
  endtask

  // ---------------------------------------------
  // run control
  // ---------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    reset_values();
    reg_access();
    timer_periods();
    carrier_pin();
    tally_and_finish();
  end

  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end
endmodule
